// File: core/owc_pkg.sv
package owc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OWC_ADDR_SYSTEM_CONTROL_TWO = 8'h00;
  localparam logic [7:0] OWC_ADDR_LOWER_TIMER_CONTROL = 8'h04;
  localparam logic [7:0] OWC_ADDR_UPPER_TIMER_CONTROL = 8'h08;
  localparam logic [7:0] OWC_ADDR_COMPARE_LOW_BYTE = 8'h0C;
  localparam logic [7:0] OWC_ADDR_COMPARE_HIGH_BYTE = 8'h10;
  localparam logic [7:0] OWC_ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OWC_ADDR_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OWC_ADDR_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] OWC_ADDR_COUNT = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OWC_SYSCLK_SEL_BIT = 5;
  localparam int OWC_LOW_OSC_EN_BIT = 6;
  localparam int OWC_HIGH_OSC_EN_BIT = 7;
  localparam int OWC_RUN_BIT = 3;
  localparam int OWC_OUT_FLOP_BIT = 7;
  localparam int OWC_SRC_LSB = 4;
  localparam int OWC_IRQ_MATCH_BIT = 0;

  // ----------------------------------------------------------------
  // Field codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] OWC_UPPER_MODE_WARMUP = 3'h5;
  localparam logic [2:0] OWC_LOWER_MODE_CASCADE = 3'h3;
  localparam logic [2:0] OWC_SRC_LOW_FREQ = 3'h4;
  localparam logic [2:0] OWC_SRC_HIGH_FREQ = 3'h6;
  localparam logic [7:0] OWC_SYSTEM_CONTROL_TWO_RESET = 8'h80;
  localparam logic [7:0] OWC_TIMER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] OWC_COMPARE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Warm-up span, counted in ticks of the selected source clock
  // ----------------------------------------------------------------
  localparam logic [15:0] OWC_COMPARE_MIN = 16'h0100;
  localparam logic [15:0] OWC_COMPARE_MAX = 16'hFF00;
  localparam int OWC_LOW_FREQ_HZ = 32768;
  localparam int OWC_LOW_MIN_TIME_US = 7810;
  localparam int OWC_LOW_MAX_TIME_MS = 1990;
  localparam int OWC_HIGH_MIN_TIME_NS = 16000;
  localparam int OWC_HIGH_MAX_TIME_US = 4080;
  localparam logic [16:0] OWC_FULL_WRAP_TICKS = 17'h1_0000;

  typedef enum logic {
    OWC_CNT_STOP,
    OWC_CNT_RUN
  } owc_cnt_state_e;

  typedef struct packed {
    logic run;
    logic warmup;
    logic src_low;
    logic src_high;
    logic [7:0] cmp_hi;
  } owc_cnt_cfg_s;

  typedef struct packed {
    logic high_osc_en;
    logic low_osc_en;
    logic sys_clk_sel;
  } owc_sysctl_s;

endpackage : owc_pkg

// File: core/owc_tick_sync.sv
`timescale 1ns/1ns
module owc_tick_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [1:0] pin_i,
  output logic [1:0] tick_o
);
  import owc_pkg::*;

  logic [1:0] meta_q;
  logic [1:0] meta_d;
  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic [1:0] prev_q;
  logic [1:0] prev_d;

  // ----------------------------------------------------------------
  // Two-flop synchroniser and rising-edge detector per source
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_src
      always_comb begin
        meta_d[g] = pin_i[g];
        sync_d[g] = meta_q[g];
        prev_d[g] = sync_q[g];
      end
      // Edge detection looks only at the second stage and its delayed copy
      assign tick_o[g] = ce_i & sync_q[g] & ~prev_q[g];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      prev_q <= 2'h0;
    end else if (ce_i) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

endmodule : owc_tick_sync

// File: core/owc_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Running counter clears and raises the match interrupt on compare match.
// - Low source span runs 256 to 65280 ticks, 7.81 ms to 1.99 s.
// - High source span runs from minimum to maximum compare, 16 us to 4.08 ms.
// - System control bit 5 selects the system clock: 1 low, 0 high.
// - System control bit 7 enables the high oscillator; clearing stops it.
// - System control bit 6 enables the low oscillator; set starts, clear stops.
// - Upper control bit 3 runs the cascaded counter; clearing it stops counting.
// - Writing 05H to upper control selects warm-up mode, flop zero, stopped.
// - Lower control 43H picks low source, 63H high source, both cascaded.
// - Only the compare upper byte takes part in match detection.
module owc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic low_freq_clock_i,
  input wire logic high_freq_clock_i,
  output logic high_osc_en_o,
  output logic low_osc_en_o,
  output logic sys_clk_sel_o,
  output logic warmup_match_irq_o
);
  import owc_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  owc_sysctl_s sysctl_q;
  owc_sysctl_s sysctl_d;
  logic [7:0] lower_ctl_q;
  logic [7:0] lower_ctl_d;
  logic [7:0] upper_ctl_q;
  logic [7:0] upper_ctl_d;
  logic [7:0] cmp_lo_q;
  logic [7:0] cmp_lo_d;
  logic [7:0] cmp_hi_q;
  logic [7:0] cmp_hi_d;
  logic irq_status_q;
  logic irq_status_d;
  logic irq_enable_q;
  logic irq_enable_d;
  logic irq_q;
  logic irq_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  logic req;
  logic wr_take;
  logic lane0;
  logic [1:0] tick;
  logic src_tick;
  logic [15:0] count;
  logic match;
  logic running;
  owc_cnt_cfg_s cfg;

  // ----------------------------------------------------------------
  // Source clock edges
  // ----------------------------------------------------------------
  owc_tick_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i({high_freq_clock_i, low_freq_clock_i}),
    .tick_o(tick)
  );

  // Source field decode; any other code leaves the counter without ticks
  always_comb begin
    cfg.run = upper_ctl_q[OWC_RUN_BIT];
    cfg.warmup = (upper_ctl_q[2:0] == OWC_UPPER_MODE_WARMUP)
               && (lower_ctl_q[2:0] == OWC_LOWER_MODE_CASCADE);
    cfg.src_low = (lower_ctl_q[OWC_SRC_LSB+:3] == OWC_SRC_LOW_FREQ);
    cfg.src_high = (lower_ctl_q[OWC_SRC_LSB+:3] == OWC_SRC_HIGH_FREQ);
    cfg.cmp_hi = cmp_hi_q;
    src_tick = (cfg.src_low & tick[0]) | (cfg.src_high & tick[1]);
  end

  owc_warmup_cnt u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cfg_i(cfg),
    .tick_i(src_tick),
    .count_o(count),
    .match_o(match),
    .running_o(running)
  );

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Writes land on the edge where the master sees ack, so a held
  // request never commits twice and the visible timing matches it.
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_take = req & wb_we_i & ack_q;
  assign lane0 = wb_sel_i[0];

  always_comb begin
    ack_d = req & ~ack_q;
    rdata_d = rdata_q;
    if (req && !ack_q) begin
      rdata_d = 32'h0000_0000;
      case (wb_adr_i)
        OWC_ADDR_SYSTEM_CONTROL_TWO: begin
          rdata_d[OWC_HIGH_OSC_EN_BIT] = sysctl_q.high_osc_en;
          rdata_d[OWC_LOW_OSC_EN_BIT] = sysctl_q.low_osc_en;
          rdata_d[OWC_SYSCLK_SEL_BIT] = sysctl_q.sys_clk_sel;
        end
        OWC_ADDR_LOWER_TIMER_CONTROL: begin
          rdata_d[7:0] = lower_ctl_q;
        end
        OWC_ADDR_UPPER_TIMER_CONTROL: begin
          rdata_d[7:0] = upper_ctl_q;
        end
        OWC_ADDR_COMPARE_LOW_BYTE: begin
          rdata_d[7:0] = cmp_lo_q;
        end
        OWC_ADDR_COMPARE_HIGH_BYTE: begin
          rdata_d[7:0] = cmp_hi_q;
        end
        OWC_ADDR_IRQ_STATUS: begin
          rdata_d[OWC_IRQ_MATCH_BIT] = irq_status_q;
        end
        OWC_ADDR_IRQ_ENABLE: begin
          rdata_d[OWC_IRQ_MATCH_BIT] = irq_enable_q;
        end
        OWC_ADDR_COUNT: begin
          rdata_d[15:0] = count;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register writes and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    sysctl_d = sysctl_q;
    lower_ctl_d = lower_ctl_q;
    upper_ctl_d = upper_ctl_q;
    cmp_lo_d = cmp_lo_q;
    cmp_hi_d = cmp_hi_q;
    irq_enable_d = irq_enable_q;
    irq_status_d = irq_status_q;
    if (wr_take && lane0) begin
      case (wb_adr_i)
        OWC_ADDR_SYSTEM_CONTROL_TWO: begin
          sysctl_d.high_osc_en = wb_dat_i[OWC_HIGH_OSC_EN_BIT];
          sysctl_d.low_osc_en = wb_dat_i[OWC_LOW_OSC_EN_BIT];
          sysctl_d.sys_clk_sel = wb_dat_i[OWC_SYSCLK_SEL_BIT];
        end
        OWC_ADDR_LOWER_TIMER_CONTROL: begin
          lower_ctl_d = wb_dat_i[7:0];
        end
        OWC_ADDR_UPPER_TIMER_CONTROL: begin
          upper_ctl_d = wb_dat_i[7:0];
        end
        OWC_ADDR_COMPARE_LOW_BYTE: begin
          cmp_lo_d = wb_dat_i[7:0];
        end
        OWC_ADDR_COMPARE_HIGH_BYTE: begin
          cmp_hi_d = wb_dat_i[7:0];
        end
        OWC_ADDR_IRQ_CLEAR: begin
          if (wb_dat_i[OWC_IRQ_MATCH_BIT]) begin
            irq_status_d = 1'b0;
          end
        end
        OWC_ADDR_IRQ_ENABLE: begin
          irq_enable_d = wb_dat_i[OWC_IRQ_MATCH_BIT];
        end
        default: begin
          irq_enable_d = irq_enable_q;
        end
      endcase
    end
    // A match in the clearing cycle must survive the clear
    if (match) begin
      irq_status_d = 1'b1;
    end
    irq_d = irq_status_d & irq_enable_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sysctl_q <= '{high_osc_en: OWC_SYSTEM_CONTROL_TWO_RESET[OWC_HIGH_OSC_EN_BIT],
                    low_osc_en: OWC_SYSTEM_CONTROL_TWO_RESET[OWC_LOW_OSC_EN_BIT],
                    sys_clk_sel: OWC_SYSTEM_CONTROL_TWO_RESET[OWC_SYSCLK_SEL_BIT]};
      lower_ctl_q <= OWC_TIMER_CONTROL_RESET;
      upper_ctl_q <= OWC_TIMER_CONTROL_RESET;
      cmp_lo_q <= OWC_COMPARE_RESET;
      cmp_hi_q <= OWC_COMPARE_RESET;
      irq_status_q <= 1'b0;
      irq_enable_q <= 1'b0;
      irq_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce_i) begin
      sysctl_q <= sysctl_d;
      lower_ctl_q <= lower_ctl_d;
      upper_ctl_q <= upper_ctl_d;
      cmp_lo_q <= cmp_lo_d;
      cmp_hi_q <= cmp_hi_d;
      irq_status_q <= irq_status_d;
      irq_enable_q <= irq_enable_d;
      irq_q <= irq_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign high_osc_en_o = sysctl_q.high_osc_en;
  assign low_osc_en_o = sysctl_q.low_osc_en;
  assign sys_clk_sel_o = sysctl_q.sys_clk_sel;
  assign warmup_match_irq_o = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_sysclk_select: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (wr_take && lane0 && wb_adr_i == OWC_ADDR_SYSTEM_CONTROL_TWO)
    |=> (sys_clk_sel_o == $past(wb_dat_i[OWC_SYSCLK_SEL_BIT])))
    else $error("clock select bit not taken from bit 5");

  a_high_osc_bit: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (wr_take && lane0 && wb_adr_i == OWC_ADDR_SYSTEM_CONTROL_TWO)
    |=> (high_osc_en_o == $past(wb_dat_i[OWC_HIGH_OSC_EN_BIT])))
    else $error("high oscillator enable not taken from bit 7");

  a_low_osc_bit: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (wr_take && lane0 && wb_adr_i == OWC_ADDR_SYSTEM_CONTROL_TWO)
    |=> (low_osc_en_o == $past(wb_dat_i[OWC_LOW_OSC_EN_BIT])))
    else $error("low oscillator enable not taken from bit 6");

  a_run_stop: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (running && !upper_ctl_q[OWC_RUN_BIT]) |=> !running)
    else $error("counter kept running after run bit cleared");

  a_mode_write: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (wr_take && lane0 && wb_adr_i == OWC_ADDR_UPPER_TIMER_CONTROL && wb_dat_i[7:0] == 8'h05)
    |=> (upper_ctl_q[2:0] == OWC_UPPER_MODE_WARMUP && !upper_ctl_q[OWC_OUT_FLOP_BIT]) ##1 !running)
    else $error("05H did not select stopped warm-up mode");

  a_source_pick: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (wr_take && lane0 && wb_adr_i == OWC_ADDR_LOWER_TIMER_CONTROL && wb_dat_i[7:0] == 8'h43)
    |=> (cfg.src_low && !cfg.src_high && !lower_ctl_q[OWC_OUT_FLOP_BIT]))
    else $error("43H did not select the low source");

  a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (match && irq_enable_q) |=> ##1 warmup_match_irq_o)
    else $error("enabled match did not raise the interrupt");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // A taken request is answered in the very next cycle, with no wait states
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (req && !ack_q) |=> wb_ack_o)
    else $error("request not answered in the next cycle");

  a_count_read: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (req && !ack_q && !wb_we_i && wb_adr_i == OWC_ADDR_COUNT)
    |=> (wb_dat_o[15:0] == $past(count)))
    else $error("count read does not show the counter");

  a_high_source: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (wr_take && lane0 && wb_adr_i == OWC_ADDR_LOWER_TIMER_CONTROL && wb_dat_i[7:0] == 8'h63)
    |=> (cfg.src_high && !cfg.src_low && !lower_ctl_q[OWC_OUT_FLOP_BIT]))
    else $error("63H did not select the high source");

  // Status must not be lost to a clear that lands with the match
  a_match_sets: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    match |=> irq_status_q)
    else $error("match did not set the status bit");

  a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (irq_status_q && !(wr_take && lane0 && wb_adr_i == OWC_ADDR_IRQ_CLEAR && wb_dat_i[OWC_IRQ_MATCH_BIT]))
    |=> irq_status_q)
    else $error("status bit dropped without a clear");

  a_status_clear: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (wr_take && lane0 && wb_adr_i == OWC_ADDR_IRQ_CLEAR && wb_dat_i[OWC_IRQ_MATCH_BIT] && !match)
    |=> !irq_status_q)
    else $error("clear did not drop the status bit");

  a_osc_hold: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    !(wr_take && lane0 && wb_adr_i == OWC_ADDR_SYSTEM_CONTROL_TWO) |=> $stable(sysctl_q))
    else $error("system control changed without a write");

endmodule : owc_top

// File: core/owc_warmup_cnt.sv
`timescale 1ns/1ns
module owc_warmup_cnt (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire owc_pkg::owc_cnt_cfg_s cfg_i,
  input wire logic tick_i,
  output logic [15:0] count_o,
  output logic match_o,
  output logic running_o
);
  import owc_pkg::*;

  owc_cnt_state_e st_q;
  owc_cnt_state_e st_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic match_q;
  logic match_d;
  logic [15:0] nxt;
  logic hit;
  logic enabled;

  assign enabled = cfg_i.run & cfg_i.warmup;
  assign nxt = cnt_q + 16'h0001;
  // Low byte of the compare value never takes part
  assign hit = (nxt[15:8] == cfg_i.cmp_hi) && (nxt[7:0] == 8'h00);

  // ----------------------------------------------------------------
  // Count sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    match_d = 1'b0;
    case (st_q)
      OWC_CNT_STOP: begin
        if (enabled) begin
          st_d = OWC_CNT_RUN;
          cnt_d = 16'h0000;
        end
      end
      OWC_CNT_RUN: begin
        if (!enabled) begin
          st_d = OWC_CNT_STOP;
        end else if (tick_i) begin
          if (hit) begin
            cnt_d = 16'h0000;
            match_d = 1'b1;
          end else begin
            cnt_d = nxt;
          end
        end
      end
      default: begin
        st_d = OWC_CNT_STOP;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= OWC_CNT_STOP;
      cnt_q <= 16'h0000;
      match_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      match_q <= match_d;
    end
  end

  assign count_o = cnt_q;
  assign match_o = match_q;
  assign running_o = (st_q == OWC_CNT_RUN);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [16:0] span_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && (st_q == OWC_CNT_STOP || match_q))) begin
      span_q <= 17'h0_0000;
    end else if (ce_i && st_q == OWC_CNT_RUN && tick_i) begin
      span_q <= span_q + 17'h0_0001;
    end
  end

  a_match_clears: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (running_o && enabled && tick_i && hit) |=> (match_o && count_o == 16'h0000))
    else $error("match did not clear the counter");

  a_warmup_span: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    $rose(match_o) |-> (span_q == ((cfg_i.cmp_hi == 8'h00) ? OWC_FULL_WRAP_TICKS : {1'b0, cfg_i.cmp_hi, 8'h00})))
    else $error("warm-up span differs from compare upper byte times 256");

  a_low_byte_ignored: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    match_o |-> ($past(cnt_q) == {cfg_i.cmp_hi, 8'h00} - 16'h0001))
    else $error("match not at upper-byte boundary");

  a_start_zero: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (!running_o && enabled) |=> (running_o && count_o == 16'h0000))
    else $error("start did not zero the counter");

  a_count_step: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (running_o && enabled && tick_i && !hit) |=> (count_o == $past(count_o) + 16'h0001))
    else $error("counter did not step by one");

  a_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (running_o && enabled && !tick_i) |=> $stable(count_o))
    else $error("counter moved without a tick");

endmodule : owc_warmup_cnt

// File: dv/owc_top_tb.sv
`timescale 1ns/1ns
module owc_top_tb;
  import owc_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Two runs of 256 ticks at 8 cycles each, plus register traffic
  localparam int TIMEOUT_CYCLES = 20000;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdata;
  logic low_freq_clock_i, high_freq_clock_i;
  logic high_osc_en_o, low_osc_en_o, sys_clk_sel_o, warmup_match_irq_o;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  owc_top uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .low_freq_clock_i(low_freq_clock_i), .high_freq_clock_i(high_freq_clock_i),
    .high_osc_en_o(high_osc_en_o), .low_osc_en_o(low_osc_en_o),
    .sys_clk_sel_o(sys_clk_sel_o), .warmup_match_irq_o(warmup_match_irq_o)
  );

  always #4 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Request stands until the rising edge at which ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 100);
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      $display("ERROR bus ack expected 1 seen timeout");
      results();
    end
    rdata = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    bus(1'b1, adr, wd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    bus(1'b0, adr, 32'h0000_0000);
    check(what, rdata, exp);
  endtask : rd_chk

  // Order is high oscillator enable, low oscillator enable, clock select
  task automatic pins(input logic [2:0] exp);
    @(negedge clk_i);
    check("osc pins", {29'h0, high_osc_en_o, low_osc_en_o, sys_clk_sel_o}, {29'h0, exp});
  endtask : pins

  task automatic irq_chk(input logic exp);
    @(negedge clk_i);
    check("irq", {31'h0, warmup_match_irq_o}, {31'h0, exp});
  endtask : irq_chk

  // Bounded wait; the match and status stages add a few cycles
  task automatic wait_irq();
    int t;
    t = 0;
    do begin
      @(negedge clk_i);
      t++;
    end while (warmup_match_irq_o !== 1'b1 && t < 20);
    check("irq raised", {31'h0, warmup_match_irq_o}, 32'h0000_0001);
  endtask : wait_irq

  // Each level lasts 4 cycles, above the synchroniser's minimum of 1
  task automatic ticks(input logic hi, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (hi) begin
        high_freq_clock_i <= 1'b1;
      end else begin
        low_freq_clock_i <= 1'b1;
      end
      repeat (4) @(posedge clk_i);
      high_freq_clock_i <= 1'b0;
      low_freq_clock_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : ticks

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      n_errors++;
      $display("ERROR run length expected %0d seen timeout", TIMEOUT_CYCLES);
      results();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    low_freq_clock_i = 1'b0;
    high_freq_clock_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    pins(3'b100);
    rd_chk(OWC_ADDR_SYSTEM_CONTROL_TWO, 32'h0000_0080, "sysctl reset");
    rd_chk(8'h24, 32'h0000_0000, "unmapped read");
    // Move to low clock
    wr(OWC_ADDR_SYSTEM_CONTROL_TWO, 32'h0000_00C0);
    pins(3'b110);
    wr(OWC_ADDR_LOWER_TIMER_CONTROL, 32'h0000_0043);
    wr(OWC_ADDR_UPPER_TIMER_CONTROL, 32'h0000_0005);
    wr(OWC_ADDR_COMPARE_LOW_BYTE, 32'h0000_00FF);
    wr(OWC_ADDR_COMPARE_HIGH_BYTE, 32'h0000_0001);
    wr(OWC_ADDR_IRQ_ENABLE, 32'h0000_0001);
    ticks(1'b0, 2);
    rd_chk(OWC_ADDR_COUNT, 32'h0000_0000, "count in stopped mode");
    wr(OWC_ADDR_UPPER_TIMER_CONTROL, 32'h0000_000D);
    ticks(1'b0, 255);
    rd_chk(OWC_ADDR_COUNT, 32'h0000_00FF, "count before match");
    irq_chk(1'b0);
    ticks(1'b0, 1);
    wait_irq();
    rd_chk(OWC_ADDR_IRQ_STATUS, 32'h0000_0001, "status on match");
    rd_chk(OWC_ADDR_COUNT, 32'h0000_0000, "count after match");
    wr(OWC_ADDR_UPPER_TIMER_CONTROL, 32'h0000_0005);
    wr(OWC_ADDR_SYSTEM_CONTROL_TWO, 32'h0000_00E0);
    pins(3'b111);
    wr(OWC_ADDR_SYSTEM_CONTROL_TWO, 32'h0000_0060);
    pins(3'b011);
    rd_chk(OWC_ADDR_SYSTEM_CONTROL_TWO, 32'h0000_0060, "sysctl readback");
    ticks(1'b0, 3);
    rd_chk(OWC_ADDR_COUNT, 32'h0000_0000, "count after stop");
    wr(OWC_ADDR_IRQ_CLEAR, 32'h0000_0001);
    irq_chk(1'b0);
    rd_chk(OWC_ADDR_IRQ_STATUS, 32'h0000_0000, "status cleared");
    rd_chk(OWC_ADDR_IRQ_CLEAR, 32'h0000_0000, "clear reads zero");
    // Restart from zero, then ticks on the unselected pin
    wr(OWC_ADDR_UPPER_TIMER_CONTROL, 32'h0000_000D);
    ticks(1'b0, 2);
    rd_chk(OWC_ADDR_COUNT, 32'h0000_0002, "count after restart");
    ticks(1'b1, 2);
    rd_chk(OWC_ADDR_COUNT, 32'h0000_0002, "count unselected pin");
    wr(OWC_ADDR_UPPER_TIMER_CONTROL, 32'h0000_0005);
    ticks(1'b0, 2);
    rd_chk(OWC_ADDR_COUNT, 32'h0000_0002, "count held after stop");
    // Move to high clock with the interrupt masked first
    wr(OWC_ADDR_SYSTEM_CONTROL_TWO, 32'h0000_00E0);
    pins(3'b111);
    wr(OWC_ADDR_LOWER_TIMER_CONTROL, 32'h0000_0063);
    wr(OWC_ADDR_IRQ_ENABLE, 32'h0000_0000);
    wr(OWC_ADDR_UPPER_TIMER_CONTROL, 32'h0000_000D);
    ticks(1'b1, 256);
    rd_chk(OWC_ADDR_IRQ_STATUS, 32'h0000_0001, "status high source");
    irq_chk(1'b0);
    wr(OWC_ADDR_IRQ_ENABLE, 32'h0000_0001);
    wait_irq();
    wr(OWC_ADDR_UPPER_TIMER_CONTROL, 32'h0000_0005);
    wr(OWC_ADDR_SYSTEM_CONTROL_TWO, 32'h0000_00C0);
    pins(3'b110);
    wr(OWC_ADDR_SYSTEM_CONTROL_TWO, 32'h0000_0080);
    pins(3'b100);
    wr(OWC_ADDR_IRQ_CLEAR, 32'h0000_0001);
    irq_chk(1'b0);
    results();
  end

endmodule : owc_top_tb
